/* File: design/cis_top.sv */
// Comparator input select registers and analog switch decode.
// Assumes the core's special-function register bus: one-cycle write and
// read strobes with page and address, read data taken the cycle after.
//
// Notes on behaviour
// [RULE_01] Comparator 0 select is at 0x9F, page 0x0, RW, resets to ones.
// [RULE_02] Comparator 1 select is at 0x9E with the same layout and reset.
// [RULE_03] Bits 7:4 pick the negative input: pins, digital supply, ground.
// [RULE_04] Bits 3:0 pick the positive input: pins, battery, main supply.
// [RULE_05] Code 1100 in either field routes the touch sense compare level.
// [RULE_06] Code 1101 in either field routes half the main supply.
// [RULE_07] Comparator 1 decodes its fields exactly like comparator 0.
// [RULE_08] Software avoids reserved codes; they leave the input open.
`default_nettype none
`include "cis_params.svh"
module cis_top
    import cis_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [3:0]   i_sfr_page,
    input  wire logic [7:0]   i_sfr_addr,
    input  wire logic         i_sfr_wr,
    input  wire logic         i_sfr_rd,
    input  wire logic [7:0]   i_sfr_wdata,
    output logic      [7:0]   o_sfr_rdata,
    output logic              o_sfr_hit,
    output var cis_cmp_sel_t  o_cmp0_sel,
    output var cis_cmp_sel_t  o_cmp1_sel
);

    logic [7:0]   comparator0_input_select;
    logic [7:0]   comparator1_input_select;
    logic [7:0]   next_cmp0;
    logic [7:0]   next_cmp1;
    logic [7:0]   rdata;
    logic [7:0]   next_rdata;
    logic         hit;
    logic         next_hit;
    cis_cmp_sel_t sel0;
    cis_cmp_sel_t sel1;
    cis_cmp_sel_t next_sel0;
    cis_cmp_sel_t next_sel1;
    logic         sel0_page;
    logic         sel1_page;
    logic [3:0]   cmp0_neg;
    logic [3:0]   cmp0_pos;
    logic [3:0]   cmp1_neg;
    logic [3:0]   cmp1_pos;

    // Shared field decode; positive and negative differ only in codes 0111
    // (pin or open), 1110 and 1111 (which supply).
    function automatic cis_sel_t decode(input logic [3:0] code,
                                        input logic       is_pos);
        cis_sel_t s;
        s = '0;
        case (code)
            `CIS_CODE_PIN0:  s.p0_0_1 = 1'b1;            // [RULE_03] [RULE_04]
            `CIS_CODE_PIN1:  s.p0_2_3 = 1'b1;
            `CIS_CODE_PIN2:  s.p0_4_5 = 1'b1;
            `CIS_CODE_PIN3:  s.p0_6_7 = 1'b1;
            `CIS_CODE_P1A:   s.p1_45  = 1'b1;
            `CIS_CODE_P1B: begin
                // Negative field has no pin here, so it stays open.
                if (is_pos) begin
                    s.p1_6 = 1'b1;                        // [RULE_04]
                end else begin
                    s.open_in = 1'b1;                     // [RULE_08]
                end
            end
            `CIS_CODE_TOUCH: s.touch = 1'b1;              // [RULE_05]
            `CIS_CODE_HALF:  s.half  = 1'b1;              // [RULE_06]
            `CIS_CODE_SUPPLY: begin
                if (is_pos) begin
                    s.vbat = 1'b1;                        // [RULE_04]
                end else begin
                    s.vdig = 1'b1;                        // [RULE_03]
                end
            end
            `CIS_CODE_TOP: begin
                if (is_pos) begin
                    s.vmain = 1'b1;                       // [RULE_04]
                end else begin
                    s.gnd = 1'b1;                         // [RULE_03]
                end
            end
            default: s.open_in = 1'b1;                    // [RULE_08]
        endcase
        return s;
    endfunction

    assign sel0_page = (i_sfr_page == `CIS_PAGE) &&
                       (i_sfr_addr == `CIS_ADDR_CMP0);
    assign sel1_page = (i_sfr_page == `CIS_PAGE) &&
                       (i_sfr_addr == `CIS_ADDR_CMP1);

    // Register writes and registered read data; unmapped reads return zero.
    always_comb begin
        next_cmp0  = comparator0_input_select;
        next_cmp1  = comparator1_input_select;
        next_rdata = rdata;
        next_hit   = 1'b0;
        if (i_sfr_wr && sel0_page) begin
            next_cmp0 = i_sfr_wdata;                      // [RULE_01]
        end
        if (i_sfr_wr && sel1_page) begin
            next_cmp1 = i_sfr_wdata;                      // [RULE_02]
        end
        if (i_sfr_rd) begin
            next_hit = sel0_page || sel1_page;
            if (sel0_page) begin
                next_rdata = comparator0_input_select;    // [RULE_01]
            end else if (sel1_page) begin
                next_rdata = comparator1_input_select;    // [RULE_02]
            end else begin
                next_rdata = `CIS_RDATA_IDLE;
            end
        end
        // Reset wins over a write in the same cycle, so the decoded
        // switches below come up matching the all-ones register value.
        if (i_sys_rst) begin
            next_cmp0 = `CIS_RESET_VALUE;                 // [RULE_01]
            next_cmp1 = `CIS_RESET_VALUE;                 // [RULE_02]
        end
    end

    // Switch enables are decoded from the next value so that they change
    // on the same edge as the register, never glitching between codes.
    always_comb begin
        next_sel0.neg = decode(next_cmp0[`CIS_NEG_MSB:`CIS_NEG_LSB], 1'b0);
        next_sel0.pos = decode(next_cmp0[`CIS_POS_MSB:`CIS_POS_LSB], 1'b1);
        // Same decode function for both comparators. [RULE_07]
        next_sel1.neg = decode(next_cmp1[`CIS_NEG_MSB:`CIS_NEG_LSB], 1'b0);
        next_sel1.pos = decode(next_cmp1[`CIS_POS_MSB:`CIS_POS_LSB], 1'b1);
    end

    // Register and read state; reset puts both selects at all ones.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            comparator0_input_select <= `CIS_RESET_VALUE; // [RULE_01]
            comparator1_input_select <= `CIS_RESET_VALUE; // [RULE_02]
            rdata <= `CIS_RDATA_IDLE;
            hit   <= 1'b0;
        end else begin
            comparator0_input_select <= next_cmp0;
            comparator1_input_select <= next_cmp1;
            rdata <= next_rdata;
            hit   <= next_hit;
        end
    end

    // Switch enables need no reset branch: the next value already carries
    // the reset code, so the switches never disagree with the register.
    always_ff @(posedge i_clk) begin
        sel0 <= next_sel0;
        sel1 <= next_sel1;
    end

    assign o_sfr_rdata = rdata;
    assign o_sfr_hit   = hit;
    assign o_cmp0_sel  = sel0;
    assign o_cmp1_sel  = sel1;

    // Field views of both registers for the checks below.
    assign cmp0_neg = comparator0_input_select[`CIS_NEG_MSB:`CIS_NEG_LSB];
    assign cmp0_pos = comparator0_input_select[`CIS_POS_MSB:`CIS_POS_LSB];
    assign cmp1_neg = comparator1_input_select[`CIS_NEG_MSB:`CIS_NEG_LSB];
    assign cmp1_pos = comparator1_input_select[`CIS_POS_MSB:`CIS_POS_LSB];

    // Checks on register behaviour and decode.
    a_cmp0_write: assert property ( // [RULE_01]
        @(posedge i_clk) disable iff (i_sys_rst)
        i_sfr_wr && sel0_page
        |=> comparator0_input_select == $past(i_sfr_wdata))
        else $error("cmp0 write lost");
    a_cmp1_write: assert property ( // [RULE_02]
        @(posedge i_clk) disable iff (i_sys_rst)
        i_sfr_wr && sel1_page
        |=> comparator1_input_select == $past(i_sfr_wdata))
        else $error("cmp1 write lost");
    a_reset_ones: assert property ( // [RULE_01] [RULE_02]
        @(posedge i_clk)
        i_sys_rst |=> comparator0_input_select == `CIS_RESET_VALUE &&
                      comparator1_input_select == `CIS_RESET_VALUE)
        else $error("reset value wrong");
    a_reset_sel: assert property ( // [RULE_03] [RULE_04]
        @(posedge i_clk)
        i_sys_rst |=> sel0 == sel1 && sel0.pos.vmain && sel0.neg.gnd)
        else $error("reset switch set wrong");
    a_sel_onehot: assert property ( // [RULE_07]
        @(posedge i_clk) disable iff (i_sys_rst)
        $onehot(sel0.pos) && $onehot(sel0.neg) &&
        $onehot(sel1.pos) && $onehot(sel1.neg))
        else $error("switch set not one-hot");
    a_neg_ground: assert property ( // [RULE_03]
        @(posedge i_clk) disable iff (i_sys_rst)
        cmp0_neg == `CIS_CODE_TOP |-> sel0.neg.gnd && $onehot(sel0.neg))
        else $error("neg ground decode");
    a_neg_digital: assert property ( // [RULE_03]
        @(posedge i_clk) disable iff (i_sys_rst)
        cmp1_neg == `CIS_CODE_SUPPLY |-> sel1.neg.vdig)
        else $error("neg digital supply decode");
    a_pos_main: assert property ( // [RULE_04]
        @(posedge i_clk) disable iff (i_sys_rst)
        cmp0_pos == `CIS_CODE_TOP |-> sel0.pos.vmain && $onehot(sel0.pos))
        else $error("pos main decode");
    a_pos_battery: assert property ( // [RULE_04]
        @(posedge i_clk) disable iff (i_sys_rst)
        cmp1_pos == `CIS_CODE_SUPPLY |-> sel1.pos.vbat)
        else $error("pos battery decode");
    a_touch_sel: assert property ( // [RULE_05]
        @(posedge i_clk) disable iff (i_sys_rst)
        sel0.pos.touch == (cmp0_pos == `CIS_CODE_TOUCH) &&
        sel0.neg.touch == (cmp0_neg == `CIS_CODE_TOUCH))
        else $error("touch decode");
    a_half_sel: assert property ( // [RULE_06]
        @(posedge i_clk) disable iff (i_sys_rst)
        sel1.neg.half == (cmp1_neg == `CIS_CODE_HALF) &&
        sel1.pos.half == (cmp1_pos == `CIS_CODE_HALF))
        else $error("half decode");
    a_same_decode: assert property ( // [RULE_07]
        @(posedge i_clk) disable iff (i_sys_rst)
        comparator0_input_select == comparator1_input_select
        |-> sel0 == sel1)
        else $error("decode mismatch");
    a_read_back: assert property ( // [RULE_01]
        @(posedge i_clk) disable iff (i_sys_rst)
        i_sfr_rd && sel0_page && !i_sfr_wr
        |=> o_sfr_hit && o_sfr_rdata == $past(comparator0_input_select))
        else $error("read back wrong");
    a_unmapped_read: assert property ( // [RULE_01] [RULE_02]
        @(posedge i_clk) disable iff (i_sys_rst)
        i_sfr_rd && !sel0_page && !sel1_page
        |=> !o_sfr_hit && o_sfr_rdata == `CIS_RDATA_IDLE)
        else $error("unmapped read answered");
    a_neg_open7: assert property ( // [RULE_08]
        @(posedge i_clk) disable iff (i_sys_rst)
        cmp1_neg == `CIS_CODE_P1B |-> sel1.neg.open_in)
        else $error("reserved not open");

    c_write0: cover property (@(posedge i_clk) i_sfr_wr && sel0_page);
    c_write1: cover property (@(posedge i_clk) i_sfr_wr && sel1_page);
    c_touch:  cover property (@(posedge i_clk) sel1.pos.touch);
    c_half:   cover property (@(posedge i_clk) sel0.neg.half);
    c_open:   cover property (@(posedge i_clk) sel0.pos.open_in);

endmodule
`default_nettype wire

/* File: design/cis_params.svh */
// Constants for the comparator input select register bank.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CIS_PARAMS_SVH
`define CIS_PARAMS_SVH
`define CIS_PAGE          4'h0
`define CIS_ADDR_CMP0     8'h9F
`define CIS_ADDR_CMP1     8'h9E
`define CIS_RESET_VALUE   8'hFF
`define CIS_RDATA_IDLE    8'h00
`define CIS_NEG_MSB       7
`define CIS_NEG_LSB       4
`define CIS_POS_MSB       3
`define CIS_POS_LSB       0
`define CIS_CODE_PIN0     4'h0
`define CIS_CODE_PIN1     4'h1
`define CIS_CODE_PIN2     4'h2
`define CIS_CODE_PIN3     4'h3
`define CIS_CODE_P1A      4'h6
`define CIS_CODE_P1B      4'h7
`define CIS_CODE_TOUCH    4'hC
`define CIS_CODE_HALF     4'hD
`define CIS_CODE_SUPPLY   4'hE
`define CIS_CODE_TOP      4'hF
`define CIS_ONEHOT_W      13
`endif

/* File: design/cis_pkg.sv */
// Types for the comparator input select register bank.
// Assumes the parameter header is on the include path.
`default_nettype none
`include "cis_params.svh"
package cis_pkg;
    // One-hot analog switch enables for one comparator input.
    typedef struct packed {
        logic p0_0_1; // Port 0 bit 0 (pos) or bit 1 (neg).
        logic p0_2_3;
        logic p0_4_5;
        logic p0_6_7;
        logic p1_45;  // Port 1 bit 4 (pos) or bit 5 (neg).
        logic p1_6;   // Port 1 bit 6, positive only.
        logic touch;  // Capacitive touch sense compare level.
        logic half;   // Main supply divided by two.
        logic vbat;   // Battery supply, positive only.
        logic vdig;   // Regulated digital supply, negative only.
        logic vmain;  // Main supply, positive only.
        logic gnd;    // Ground, negative only.
        logic open_in; // Reserved code: input left unconnected.
    } cis_sel_t;
    typedef struct packed {
        cis_sel_t pos;
        cis_sel_t neg;
    } cis_cmp_sel_t;
endpackage
`default_nettype wire

/* File: verification/comparator_input_select_test.sv */
// Self-checking bench for the comparator input select register bank.
// Assumes the package and the design module are compiled before this file.
`default_nettype none
module comparator_input_select_test
    import cis_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 100ps;

    logic         clk = 1'h0;
    logic         sys_rst = 1'h1;
    logic [3:0]   page;
    logic [7:0]   addr;
    logic         wr;
    logic         rd;
    logic [7:0]   wdata;
    logic [7:0]   rdata;
    logic         hit;
    cis_cmp_sel_t sel0;
    cis_cmp_sel_t sel1;
    logic [7:0]   regs [2]; // Index 1 is comparator 0, index 0 comparator 1.
    int           mismatches = 0;
    int           checks = 0;
    integer       seed = 38;

    // The 40 MHz core clock.
    always #12.5 clk = ~clk;

    cis_top DUT (.i_clk(clk), .i_sys_rst(sys_rst), .i_sfr_page(page),
        .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
        .o_cmp0_sel(sel0), .o_cmp1_sel(sel1));

    // One-hot switch set expected for one 4-bit field code.
    function automatic cis_sel_t dec(input logic [3:0] c, input logic pos);
        cis_sel_t s;
        s = '0;
        case (c)
            4'h0: s.p0_0_1 = 1'h1;
            4'h1: s.p0_2_3 = 1'h1;
            4'h2: s.p0_4_5 = 1'h1;
            4'h3: s.p0_6_7 = 1'h1;
            4'h6: s.p1_45 = 1'h1;
            4'h7: {s.p1_6, s.open_in} = {pos, !pos};
            4'hc: s.touch = 1'h1;
            4'hd: s.half = 1'h1;
            4'he: {s.vbat, s.vdig} = {pos, !pos};
            4'hf: {s.vmain, s.gnd} = {pos, !pos};
            default: s.open_in = 1'h1;
        endcase
        return s;
    endfunction

    // Both fields of one register; the positive field sits in the lower half.
    function automatic cis_cmp_sel_t exp_sel(input logic [7:0] v);
        return {dec(v[3:0], 1'h1), dec(v[7:4], 1'h0)};
    endfunction

    // Every comparison passes through here so that it is counted.
    task automatic chk(input string what, input logic [25:0] seen,
                       input logic [25:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus cycle; strobes stay up so that back-to-back calls are legal.
    task automatic op(input logic w, input logic r, input logic [3:0] pg,
                      input logic [7:0] ad, input logic [7:0] d);
        logic       m;
        logic [7:0] old;
        m = (pg == 4'h0) && (ad == 8'h9e || ad == 8'h9f);
        old = regs[ad[0]];
        wr = w;
        rd = r;
        page = pg;
        addr = ad;
        wdata = d;
        @(negedge clk);
        chk("hit", hit, r & m);
        if (r) chk("rdata", rdata, m ? old : 8'h00);
        if (w && m) regs[ad[0]] = d;
        chk("cmp0 sel", sel0, exp_sel(regs[1]));
        chk("cmp1 sel", sel1, exp_sel(regs[0]));
    endtask

    // Drops the strobes and lets one edge pass.
    task automatic idle(input string name);
        wr = 1'h0;
        rd = 1'h0;
        @(negedge clk);
        $display("test %s finished", name);
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence: reset values, every code, random traffic, reset again.
    initial begin
        logic [31:0] a;
        {page, addr, wr, rd, wdata} = '0;
        regs[0] = 8'hff;
        regs[1] = 8'hff;
        repeat (16) @(negedge clk);
        // The switches already show the all-ones code while reset holds.
        chk("sel0 in reset", sel0, exp_sel(8'hff));
        chk("sel1 in reset", sel1, exp_sel(8'hff));
        chk("hit in reset", hit, 1'h0);
        sys_rst = 1'h0;
        op(1'h0, 1'h1, 4'h0, 8'h9f, 8'h00);
        op(1'h0, 1'h1, 4'h0, 8'h9e, 8'h00);
        idle("reset values");
        // Each code lands in both fields of both registers.
        for (int c = 0; c < 16; c++) begin
            op(1'h1, 1'h0, 4'h0, 8'h9f, {c[3:0], ~c[3:0]});
            op(1'h1, 1'h1, 4'h0, 8'h9e, {~c[3:0], c[3:0]});
            op(1'h0, 1'h1, 4'h0, 8'h9f, 8'h00);
        end
        idle("all codes");
        // Wrong page and unmapped address must leave both registers alone.
        op(1'h1, 1'h1, 4'h1, 8'h9f, 8'h00);
        op(1'h1, 1'h1, 4'h0, 8'ha0, 8'h00);
        op(1'h0, 1'h1, 4'h0, 8'h9e, 8'h00);
        idle("unmapped");
        repeat (80) begin
            a = $random(seed);
            op(a[0], a[1], a[5] ? a[19:16] : 4'h0,
               a[4] ? (a[3] ? 8'h9e : 8'h9f) : a[15:8], a[31:24]);
        end
        idle("random traffic");
        // A second reset in mid-run must bring back all ones.
        sys_rst = 1'h1;
        @(negedge clk);
        chk("sel1 in reset", sel1, exp_sel(8'hff));
        chk("sel0 in reset", sel0, exp_sel(8'hff));
        chk("rdata in reset", rdata, 8'h00);
        sys_rst = 1'h0;
        regs[0] = 8'hff;
        regs[1] = 8'hff;
        op(1'h0, 1'h1, 4'h0, 8'h9e, 8'h00);
        op(1'h0, 1'h1, 4'h0, 8'h9f, 8'h00);
        idle("second reset");
        test_done();
    end

    // Watchdog: the sequence needs about 160 cycles, so 2000 means a hang.
    initial begin
        #50000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
